/* File: hdl/ddrsi_top.sv */
// Device-side logic of a burst-of-two DDR SRAM: pins, array, posted write and status.
//
// Overview of operation
// [RULE1] Accesses start on positive clock rises; data moves on both input clock rises.
// [RULE2] Direction high with load strobe low at positive rise starts a read.
// [RULE3] First read word two positive rises later, second on next complement rise.
// [RULE4] A read may start every positive rise and always completes.
// [RULE5] With no read selected, outputs float after the next positive rise.
// [RULE6] Direction low with load strobe low starts a write; address is captured.
// [RULE7] Write words taken on next positive then complement rise; 36 bits committed.
// [RULE8] Back-to-back writes accept one word on every input clock rise.
// [RULE9] With no write selected, pending writes finish and inputs are ignored.
// [RULE10] Each lane select is sampled with its word; deasserted lanes stay unchanged.
// [RULE11] Lane select zero gates bits 8:0, lane select one bits 17:9.
// [RULE12] Host leaves two idle cycles between a read and a following write.
// [RULE13] A write followed by reads is held and committed on the next write.
// [RULE14] A read of the held write's address returns the held, newest data.
// [RULE15] Host gives each bank its own load strobe when expanding depth.
// [RULE16] Output impedance is re-evaluated every 1024 input clock cycles.
// [RULE17] Two free-running echo clocks follow the positive and complement clocks.
// [RULE18] Valid flag rises half a cycle before read data, timed like data.
// [RULE19] Loop disable low turns the loop off: legacy mode, one-cycle read latency.
// [RULE20] Stopping or slowing the input clocks for 30 ns resets the loop.
// [RULE21] With the loop enabled, lock follows 2048 cycles of stable clock.
// [RULE22] Host keeps input clocks between 120 MHz and the rated maximum.
`timescale 1ns/1ns
`default_nettype none
module ddrsi_top
  import ddrsi_pkg::*;
#(
  parameter int AW         = DDRSI_ADDR_W,
  parameter int K_HALF_CYC = DDRSI_K_HALF_CYC
) (
  // Clock, reset and freeze.
  input  wire logic                    sys_clk,
  input  wire logic                    rst,
  input  wire logic                    clk_en,
  // Input clocks from the host, sampled as plain pins.
  input  wire logic                    k_clk,
  input  wire logic                    k_clk_n,
  // Synchronous control and address pins.
  input  wire logic                    load_strobe_n,
  input  wire logic                    rd_wr_n,
  input  wire logic [AW-1:0]           addr,
  input  wire logic [1:0]              byte_lane_select_n,
  input  wire logic                    loop_disable_n,
  // Shared data pins, split into in, out and enable.
  input  wire logic [DDRSI_WORD_W-1:0] dq_in,
  output logic      [DDRSI_WORD_W-1:0] dq_out,
  output logic                         dq_oe_n,
  // Echo clocks, valid flag and housekeeping.
  output logic                         echo_clock,
  output logic                         echo_clock_n,
  output logic                         output_valid_flag,
  output logic                         impedance_update,
  output logic                         dll_locked,
  // Classic Wishbone register slave.
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [7:0]              wb_adr_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic [31:0]             wb_dat_i,
  output logic                         wb_ack_o,
  output logic      [31:0]             wb_dat_o
);

  localparam int SYNC_W = 5 + 2 + DDRSI_WORD_W + AW;
  localparam logic [7:0] STALL_CYC = 8'(K_HALF_CYC + DDRSI_STOP_CYC);

  ////////////////////////////////////////////////////////////////////////////
  // State.

  typedef struct packed {
    logic                     k_d;
    logic                     kn_d;
    logic [7:0]               gap;
    logic                     rd1_v;
    logic [AW-1:0]            rd1_a;
    logic                     rd2_v;
    logic [AW-1:0]            rd2_a;
    logic                     wl_v;
    logic [AW-1:0]            wl_a;
    logic                     wd_v;
    logic [AW-1:0]            wd_a;
    logic [DDRSI_WORD_W-1:0]  wd_w0;
    logic [1:0]               wd_m0;
    logic                     post_v;
    logic [AW-1:0]            post_a;
    logic [DDRSI_BURST_W-1:0] post_d;
    logic [DDRSI_LANES-1:0]   post_m;
    logic [DDRSI_WORD_W-1:0]  hi_word;
    logic                     hi_pend;
    logic [DDRSI_WORD_W-1:0]  dq;
    logic                     dq_oe_n;
    logic                     valid;
    logic                     cq;
    logic                     cq_n;
    logic [9:0]               zq_cnt;
    logic                     zq_upd;
    logic [15:0]              zq_total;
    logic [11:0]              lock_cnt;
    logic                     locked;
    logic                     force_legacy;
    logic                     ack;
    logic [31:0]              rdata;
  } ddrsi_st_t;

  ddrsi_st_t st_ff;
  ddrsi_st_t nxt_st;

  logic [DDRSI_BURST_W-1:0] mem [0:(2**AW)-1];

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and edge detection.

  logic [SYNC_W-1:0]       pins_s;
  logic                    k_s;
  logic                    kn_s;
  logic                    ld_n_s;
  logic                    rw_s;
  logic                    ldis_n_s;
  logic [1:0]              bls_n_s;
  logic [DDRSI_WORD_W-1:0] dq_s;
  logic [AW-1:0]           addr_s;

  // Data and control travel through the same two stages as the clocks,
  // so their alignment to each clock edge is preserved.
  ddrsi_sync #(
    .W       (SYNC_W),
    .RST_VAL ({SYNC_W{1'b1}})
  ) u_sync (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .clk_en   (clk_en),
    .async_in ({k_clk, k_clk_n, load_strobe_n, rd_wr_n, loop_disable_n,
                byte_lane_select_n, dq_in, addr}),
    .sync_out (pins_s)
  );

  assign {k_s, kn_s, ld_n_s, rw_s, ldis_n_s, bls_n_s, dq_s, addr_s} = pins_s;

  logic k_rise;
  logic kn_rise;
  logic legacy;

  assign k_rise  = k_s & ~st_ff.k_d; // [RULE1]
  assign kn_rise = kn_s & ~st_ff.kn_d; // [RULE1]
  assign legacy  = ~ldis_n_s | st_ff.force_legacy; // [RULE19]

  ////////////////////////////////////////////////////////////////////////////
  // Array access with lane merging.

  logic                     out_v;
  logic [AW-1:0]            out_a;
  logic [DDRSI_BURST_W-1:0] rd_arr;
  logic [DDRSI_BURST_W-1:0] rd_word;
  logic [DDRSI_BURST_W-1:0] cm_arr;
  logic [DDRSI_BURST_W-1:0] cm_word;
  logic                     hit;
  logic                     mem_we;

  // Legacy mode drives one input cycle after the load, normal mode two.
  assign out_v  = legacy ? st_ff.rd1_v : st_ff.rd2_v; // [RULE3] [RULE19]
  assign out_a  = legacy ? st_ff.rd1_a : st_ff.rd2_a;
  assign rd_arr = mem[out_a];
  assign cm_arr = mem[st_ff.post_a];
  assign hit    = st_ff.post_v && (st_ff.post_a == out_a); // [RULE14]

  // A held write only replaces the lanes it enabled, both when it is
  // committed and when a read bypasses the array to see it.
  genvar gl;
  generate
    for (gl = 0; gl < DDRSI_LANES; gl++) begin : g_lane
      assign rd_word[gl*DDRSI_LANE_W +: DDRSI_LANE_W] = (hit && st_ff.post_m[gl]) ?
        st_ff.post_d[gl*DDRSI_LANE_W +: DDRSI_LANE_W] :
        rd_arr[gl*DDRSI_LANE_W +: DDRSI_LANE_W]; // [RULE14]
      assign cm_word[gl*DDRSI_LANE_W +: DDRSI_LANE_W] = st_ff.post_m[gl] ?
        st_ff.post_d[gl*DDRSI_LANE_W +: DDRSI_LANE_W] :
        cm_arr[gl*DDRSI_LANE_W +: DDRSI_LANE_W]; // [RULE10] [RULE11]
    end
  endgenerate

  // The previously held write is committed only when a newer write has
  // collected both of its words, so reads in between never collide with it.
  assign mem_we = clk_en && kn_rise && st_ff.wd_v && st_ff.post_v; // [RULE13]

  always_ff @(posedge sys_clk) begin
    if (mem_we) begin
      mem[st_ff.post_a] <= cm_word; // [RULE7] [RULE13]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  always_comb begin
    nxt_st        = st_ff;
    nxt_st.k_d    = k_s;
    nxt_st.kn_d   = kn_s;
    nxt_st.zq_upd = 1'b0;
    nxt_st.ack    = 1'b0;

    // Time since the positive clock last changed level.
    if (k_s != st_ff.k_d) begin
      nxt_st.gap = 8'h00;
    end else if (st_ff.gap != 8'hFF) begin
      nxt_st.gap = st_ff.gap + 8'h01;
    end

    // Loop lock tracking; a stalled or slowed clock restarts the count.
    if (legacy) begin
      nxt_st.lock_cnt = 12'h000; // [RULE19]
      nxt_st.locked   = 1'b0;
    end else if (st_ff.gap >= STALL_CYC) begin
      nxt_st.lock_cnt = 12'h000; // [RULE20]
      nxt_st.locked   = 1'b0;
    end else if (k_rise && !st_ff.locked) begin
      if (st_ff.lock_cnt == 12'(DDRSI_LOCK_CYC - 1)) begin
        nxt_st.locked = 1'b1; // [RULE21]
      end else begin
        nxt_st.lock_cnt = st_ff.lock_cnt + 12'h001;
      end
    end

    if (k_rise) begin
      nxt_st.cq   = 1'b1; // [RULE17]
      nxt_st.cq_n = 1'b0;

      // Impedance re-evaluation tick.
      if (st_ff.zq_cnt == 10'(DDRSI_ZQ_PERIOD - 1)) begin
        nxt_st.zq_cnt   = 10'h000; // [RULE16]
        nxt_st.zq_upd   = 1'b1;
        nxt_st.zq_total = st_ff.zq_total + 16'h0001;
      end else begin
        nxt_st.zq_cnt = st_ff.zq_cnt + 10'h001;
      end

      // Read pipeline: every loaded read advances and finishes.
      nxt_st.rd2_v = st_ff.rd1_v; // [RULE4]
      nxt_st.rd2_a = st_ff.rd1_a;
      nxt_st.rd1_v = ~ld_n_s & rw_s; // [RULE2]
      nxt_st.rd1_a = addr_s;

      // Write pipeline: address now, words on the next input cycle.
      nxt_st.wd_v = st_ff.wl_v; // [RULE8]
      nxt_st.wd_a = st_ff.wl_a;
      nxt_st.wl_v = ~ld_n_s & ~rw_s; // [RULE6]
      nxt_st.wl_a = addr_s;
      if (st_ff.wl_v) begin // [RULE9]
        nxt_st.wd_w0 = dq_s; // [RULE7]
        nxt_st.wd_m0 = ~bls_n_s; // [RULE10]
      end

      // Output slot: drive the first word or float the pins.
      if (out_v) begin
        nxt_st.dq      = rd_word[DDRSI_WORD_W-1:0]; // [RULE3]
        nxt_st.hi_word = rd_word[DDRSI_BURST_W-1:DDRSI_WORD_W];
        nxt_st.hi_pend = 1'b1;
        nxt_st.dq_oe_n = 1'b0;
      end else begin
        nxt_st.hi_pend = 1'b0;
        nxt_st.dq_oe_n = 1'b1; // [RULE5]
      end
    end

    if (kn_rise) begin
      nxt_st.cq   = 1'b0; // [RULE17]
      nxt_st.cq_n = 1'b1;

      if (st_ff.hi_pend) begin
        nxt_st.dq      = st_ff.hi_word; // [RULE3]
        nxt_st.hi_pend = 1'b0;
      end

      // The flag leads the burst that the next positive rise will drive.
      nxt_st.valid = out_v; // [RULE18]

      // Second word completes the write, which becomes the held write.
      if (st_ff.wd_v) begin
        nxt_st.post_v = 1'b1; // [RULE7] [RULE13]
        nxt_st.post_a = st_ff.wd_a;
        nxt_st.post_d = {dq_s, st_ff.wd_w0};
        nxt_st.post_m = {~bls_n_s, st_ff.wd_m0}; // [RULE10] [RULE11]
      end
    end

    // Register slave: answers one cycle after the request, every address.
    if (wb_cyc_i && wb_stb_i && !st_ff.ack) begin
      nxt_st.ack   = 1'b1;
      nxt_st.rdata = 32'h0000_0000;
      case (wb_adr_i)
        DDRSI_REG_CTRL: begin
          nxt_st.rdata[DDRSI_CTRL_LEGACY_BIT] = st_ff.force_legacy;
        end
        DDRSI_REG_STATUS: begin
          nxt_st.rdata[DDRSI_ST_LOCKED_BIT]  = st_ff.locked;
          nxt_st.rdata[DDRSI_ST_LEGACY_BIT]  = legacy;
          nxt_st.rdata[DDRSI_ST_POSTED_BIT]  = st_ff.post_v;
          nxt_st.rdata[DDRSI_ST_DRIVING_BIT] = ~st_ff.dq_oe_n;
        end
        DDRSI_REG_ZQCNT: begin
          nxt_st.rdata[15:0] = st_ff.zq_total;
        end
        default: begin
          nxt_st.rdata = 32'h0000_0000;
        end
      endcase
    end

    // Writes take effect on the edge where the master sees ack high.
    if (wb_cyc_i && wb_stb_i && wb_we_i && st_ff.ack && wb_sel_i[0] &&
        wb_adr_i == DDRSI_REG_CTRL) begin
      nxt_st.force_legacy = wb_dat_i[DDRSI_CTRL_LEGACY_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_ff              <= '0;
      st_ff.k_d          <= 1'b1;
      st_ff.kn_d         <= 1'b1;
      st_ff.dq_oe_n      <= 1'b1;
      st_ff.cq_n         <= 1'b1;
      st_ff.force_legacy <= DDRSI_CTRL_LEGACY_RST;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from the state register.

  assign dq_out            = st_ff.dq;
  assign dq_oe_n           = st_ff.dq_oe_n;
  assign echo_clock        = st_ff.cq;
  assign echo_clock_n      = st_ff.cq_n;
  assign output_valid_flag = st_ff.valid;
  assign impedance_update  = st_ff.zq_upd;
  assign dll_locked        = st_ff.locked;
  assign wb_ack_o          = st_ff.ack;
  assign wb_dat_o          = st_ff.rdata;

endmodule
`default_nettype wire

/* File: pkg/ddrsi_pkg.sv */
// Shared constants of the burst-of-two DDR SRAM interface logic.
package ddrsi_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Data path geometry.
  localparam int DDRSI_WORD_W  = 18;
  localparam int DDRSI_LANE_W  = 9;
  localparam int DDRSI_BURST_W = 36;
  localparam int DDRSI_LANES   = 4;
  localparam int DDRSI_ADDR_W  = 20;

  ////////////////////////////////////////////////////////////////////////////
  // Timing, in input clock cycles except the stop time (ns), the clock rate (MHz) and the stop and half-cycle lengths, which are in system clock cycles.
  localparam int DDRSI_ZQ_PERIOD  = 1024;
  localparam int DDRSI_LOCK_CYC   = 2048;
  localparam int DDRSI_SYS_MHZ    = 25;
  localparam int DDRSI_STOP_NS    = 30;
  // A least time, so it rounds up to whole system clock cycles.
  localparam int DDRSI_STOP_CYC   = (DDRSI_STOP_NS * DDRSI_SYS_MHZ + 999) / 1000;
  localparam int DDRSI_K_HALF_CYC = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses on the register bus.
  localparam logic [7:0] DDRSI_REG_CTRL   = 8'h00;
  localparam logic [7:0] DDRSI_REG_STATUS = 8'h04;
  localparam logic [7:0] DDRSI_REG_ZQCNT  = 8'h08;

  localparam int DDRSI_CTRL_LEGACY_BIT = 0;
  localparam logic DDRSI_CTRL_LEGACY_RST = 1'b0;

  localparam int DDRSI_ST_LOCKED_BIT  = 0;
  localparam int DDRSI_ST_LEGACY_BIT  = 1;
  localparam int DDRSI_ST_POSTED_BIT  = 2;
  localparam int DDRSI_ST_DRIVING_BIT = 3;

endpackage

/* File: hdl/ddrsi_sync.sv */
// Two-stage synchroniser for a group of pin inputs.
`timescale 1ns/1ns
`default_nettype none
module ddrsi_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset.
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic         clk_en,
  // Asynchronous pins in, synchronised copy out.
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } ddrsi_sync_st_t;

  ddrsi_sync_st_t st_ff;
  ddrsi_sync_st_t nxt_st;

  // The first stage is read only by the second.
  always_comb begin
    nxt_st = st_ff;
    if (clk_en) begin
      nxt_st.meta   = async_in;
      nxt_st.stable = st_ff.meta;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_ff <= {RST_VAL, RST_VAL};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign sync_out = st_ff.stable;

endmodule
`default_nettype wire

/* File: bench/ddrsi_assertions.sv */
// Concurrent checks on the pins and register bus of the burst SRAM interface.
`timescale 1ns/1ns
`default_nettype none
module ddrsi_assertions (
  // Clock and reset.
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        clk_en,
  // Link pins.
  input wire logic        k_clk,
  input wire logic        k_clk_n,
  input wire logic        loop_disable_n,
  input wire logic        dq_oe_n,
  input wire logic        output_valid_flag,
  input wire logic        echo_clock,
  input wire logic        echo_clock_n,
  input wire logic        impedance_update,
  input wire logic        dll_locked,
  // Register bus.
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic        wb_ack_o,
  input wire logic [31:0] wb_dat_o
);
  default clocking cb @(posedge sys_clk); endclocking
  // A frozen device cannot follow its pins, so checks rest while the enable is low.
  default disable iff (rst || !clk_en);
  // Positive clock rises seen with the loop enabled; lock must not come sooner.
  logic [11:0] krise_ff;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) krise_ff <= 12'h000;
    else if (!loop_disable_n) krise_ff <= 12'h000;
    else if ($rose(k_clk) && krise_ff != 12'hFFF) krise_ff <= krise_ff + 12'h001;
  end
  sequence s_k_rise;
    $rose(k_clk) && !k_clk_n;
  endsequence
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  a_ack_next: assert property (s_req |=> wb_ack_o) else $error("ack missing after request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
  a_unmapped_zero: assert property (wb_ack_o && wb_adr_i > 8'h08 |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_echo_follow: assert property (s_k_rise |-> ##[1:4] echo_clock && !echo_clock_n)
    else $error("echo clock missed positive rise");
  a_echo_comp: assert property ($rose(k_clk_n) |-> ##[1:4] echo_clock_n && !echo_clock)
    else $error("echo clock missed complement rise");
  a_float_on_k: assert property ($rose(dq_oe_n) |-> k_clk && !k_clk_n)
    else $error("outputs floated off a positive rise");
  a_valid_lead: assert property ($rose(output_valid_flag) |-> k_clk_n ##[3:5] !dq_oe_n)
    else $error("valid flag not half a cycle ahead of data");
  a_lock_drop: assert property ($fell(loop_disable_n) |-> ##[1:6] !dll_locked)
    else $error("lock kept with loop disabled");
  a_lock_count: assert property ($rose(dll_locked) |-> loop_disable_n && krise_ff >= 12'd2047)
    else $error("lock came too early");
  a_zq_pulse: assert property (impedance_update |=> !impedance_update [*8])
    else $error("impedance update not a lone pulse");
endmodule
bind ddrsi_top ddrsi_assertions u_chk (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .k_clk(k_clk),
  .k_clk_n(k_clk_n),
  .loop_disable_n(loop_disable_n), .dq_oe_n(dq_oe_n), .output_valid_flag(output_valid_flag),
  .echo_clock(echo_clock), .echo_clock_n(echo_clock_n), .impedance_update(impedance_update),
  .dll_locked(dll_locked), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_adr_i(wb_adr_i),
  .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o));
`default_nettype wire

/* File: bench/ddrsi_host_model.sv */
// Host controller model: input clocks, pipelined commands and read capture.
`timescale 1ns/1ns
`default_nettype none
module ddrsi_host_model
  import ddrsi_pkg::*;
#(
  parameter int AW = 6
) (
  // Pacing clock.
  input  wire logic                    sys_clk,
  // Input clocks and pins toward the device.
  output logic                         k_clk,
  output logic                         k_clk_n,
  output logic                         load_strobe_n,
  output logic                         rd_wr_n,
  output logic      [AW-1:0]           addr,
  output logic      [1:0]              byte_lane_select_n,
  output logic      [DDRSI_WORD_W-1:0] dq_in,
  // Resolved data wire, for read capture.
  input  wire logic [DDRSI_WORD_W-1:0] dq_bus,
  input  wire logic                    dq_oe_n
);
  // Command: [61] valid, [60] read, [59:56] lanes, [55:36] address, [35:0] burst.
  logic [63:0] q [$];
  logic [36:0] rq [$];
  logic [63:0] c;
  logic [63:0] p1 = '0, p2 = '0, p3 = '0, p4 = '0;
  logic [18:0] w0 = '0;
  logic [2:0]  ph = 3'h0;
  // Set by the bench to stop both input clocks where they stand.
  logic        hold = 1'b0;
  initial begin
    {k_clk, k_clk_n, load_strobe_n, rd_wr_n} = 4'h7;
    addr = '0;
    byte_lane_select_n = 2'h3;
    dq_in = '0;
  end
  // The input clocks keep one steady rate and pause only on request.
  always @(posedge sys_clk) if (!hold) begin
    ph <= ph + 3'h1;
    if (ph == 3'h0) {k_clk, k_clk_n} <= 2'h2;
    if (ph == 3'h4) begin
      {k_clk, k_clk_n} <= 2'h1;
      c = (q.size() != 0) ? q.pop_front() : 64'h0;
      load_strobe_n <= ~c[61];
      rd_wr_n <= c[60];
      addr <= c[AW+35:36];
      {p1, p2, p3, p4} <= {c, p1, p2, p3};
    end
    // Data changes midway between sampling rises so set-up and hold both get margin.
    if (ph == 3'h6 || ph == 3'h2) begin
      if (p2[61] && !p2[60]) begin
        dq_in <= (ph == 3'h6) ? p2[17:0] : p2[35:18];
        byte_lane_select_n <= (ph == 3'h6) ? p2[57:56] : p2[59:58];
      end else begin
        dq_in <= ~dq_in;
        byte_lane_select_n <= 2'h3;
      end
    end
    if (ph == 3'h6) w0 <= {dq_oe_n, dq_bus};
    if (ph == 3'h2 && p4[61] && p4[60]) rq.push_back({w0[18] | dq_oe_n, dq_bus, w0[17:0]});
  end
endmodule
`default_nettype wire

/* File: bench/tb.sv */
// Self-checking bench: bursts, masked writes, bypass reads and registers.
`timescale 1ns/1ns
`default_nettype none
module tb import ddrsi_pkg::*; ();
  logic                    sys_clk = 1'b0;
  logic                    rst = 1'b1;
  logic                    loop_disable_n = 1'b1;
  logic                    clk_en = 1'b1;
  logic [3:0]              wb_sel_i = 4'hF;
  logic                    wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0]              wb_adr_i = 8'h00;
  logic [31:0]             wb_dat_i = 32'h0, wb_dat_o, q;
  logic                    wb_ack_o, dq_oe_n, k_clk, k_clk_n, ld_n, rw, cq, cq_n, vld, zq, locked;
  logic [5:0]              addr;
  logic [1:0]              lanes_n;
  logic [DDRSI_WORD_W-1:0] dq_out, host_dq, dq_wire;
  logic [35:0]             mem [64];
  logic [35:0]             expq [$];
  int                      n_mismatch = 0, checks_done = 0, cyc = 0;
  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cyc <= cyc + 1;
  assign dq_wire = dq_oe_n ? host_dq : dq_out;
  ddrsi_top #(.AW(6)) dut (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .k_clk(k_clk), .k_clk_n(k_clk_n),
    .load_strobe_n(ld_n), .rd_wr_n(rw), .addr(addr), .byte_lane_select_n(lanes_n),
    .loop_disable_n(loop_disable_n), .dq_in(dq_wire), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
    .echo_clock(cq), .echo_clock_n(cq_n), .output_valid_flag(vld), .impedance_update(zq),
    .dll_locked(locked), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o));
  ddrsi_host_model #(.AW(6)) host (.sys_clk(sys_clk), .k_clk(k_clk), .k_clk_n(k_clk_n),
    .load_strobe_n(ld_n), .rd_wr_n(rw), .addr(addr), .byte_lane_select_n(lanes_n),
    .dq_in(host_dq), .dq_bus(dq_wire), .dq_oe_n(dq_oe_n));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [36:0] e, input logic [36:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic [7:0] a, input logic we, input logic [31:0] d, output logic [31:0] r,
                    input logic [3:0] s = 4'hF);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, we};
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    // Only the watchdog ends a wait for the answer.
    do begin
      @(posedge sys_clk);
    end while (wb_ack_o !== 1'b1);
    r = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
    @(posedge sys_clk);
  endtask
  // The reference applies each write at once; the device must look the same through its bypass.
  task automatic wr(input int a, input logic [35:0] d, input logic [3:0] ln);
    for (int i = 0; i < 4; i++) if (!ln[i]) mem[a][9*i+:9] = d[9*i+:9];
    host.q.push_back({4'h2, ln, 20'(a), d});
  endtask
  task automatic rd(input int a);
    host.q.push_back({4'h3, 4'hF, 20'(a), 36'h0});
    expq.push_back(mem[a]);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // The whole sequence needs about 18000 cycles; this allows four times that.
  initial begin
    #3000000;
    n_mismatch++;
    end_of_test();
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    wb(DDRSI_REG_CTRL, 1'b0, 32'h0, q);
    chk("ctrl reset", 37'h0, 37'(q));
    for (int i = 0; i < 6; i++) wr(i, {9{4'(i + 3)}}, 4'h0);
    for (int i = 0; i < 4; i++) rd(i);
    repeat (2) host.q.push_back(64'h0);
    for (int m = 0; m < 16; m++) begin
      wr(5, 36'h9_5A5A_5A5A ^ {9{4'(m)}}, 4'(m));
      rd(5);
      repeat (2) host.q.push_back(64'h0);
    end
    while (host.q.size() != 0) @(posedge sys_clk);
    repeat (48) @(posedge sys_clk);
    chk("reads seen", 37'h14, 37'(host.rq.size()));
    while (host.rq.size() != 0) chk("read burst", {1'b0, expq.pop_front()}, host.rq.pop_front());
    chk("dq float", 37'h1, 37'(dq_oe_n));
    while (cyc < 17600) @(posedge sys_clk);
    chk("locked", 37'h1, 37'(locked));
    wb(DDRSI_REG_ZQCNT, 1'b0, 32'h0, q);
    chk("zq count", 37'h2, 37'(q));
    wb(DDRSI_REG_STATUS, 1'b0, 32'h0, q);
    chk("status", 37'h5, 37'(q));
    host.hold <= 1'b1;
    repeat (16) @(posedge sys_clk);
    chk("stall unlock", 37'h0, 37'(locked));
    host.hold <= 1'b0;
    wb(DDRSI_REG_CTRL, 1'b1, 32'h1, q);
    wb(DDRSI_REG_CTRL, 1'b0, 32'h0, q);
    chk("ctrl", 37'h1, 37'(q));
    wb(DDRSI_REG_CTRL, 1'b1, 32'h0, q, 4'hE);
    wb(DDRSI_REG_CTRL, 1'b0, 32'h0, q);
    chk("ctrl sel", 37'h1, 37'(q));
    wb(DDRSI_REG_STATUS, 1'b0, 32'h0, q);
    chk("forced legacy", 37'h2, 37'(q & 32'h2));
    wb(8'h0C, 1'b1, 32'hFFFF_FFFF, q);
    wb(8'h0C, 1'b0, 32'h0, q);
    chk("unmapped", 37'h0, 37'(q));
    wb(DDRSI_REG_CTRL, 1'b1, 32'h0, q);
    loop_disable_n <= 1'b0;
    repeat (8) @(posedge sys_clk);
    chk("lock off", 37'h0, 37'(locked));
    wb(DDRSI_REG_STATUS, 1'b0, 32'h0, q);
    chk("pin legacy", 37'h2, 37'(q & 32'h3));
    // Twelve cycles is one and a half input clock periods, so a running echo would differ.
    clk_en <= 1'b0;
    @(posedge sys_clk);
    q = {31'h0, cq};
    repeat (12) @(posedge sys_clk);
    chk("freeze", 37'(q), 37'(cq));
    clk_en <= 1'b1;
    end_of_test();
  end
endmodule
`default_nettype wire
